// File: async_serial_port.sv
// Asynchronous serial port: byte register set, baud generator, transmitter, receiver.
// Assumes host strobes are synchronous to mclk_in; line and modem pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Host register port
    input wire serial_port_pkg::host_req_t host_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    // Serial line
    input wire logic rxd_in,
    output logic txd_out,
    // Modem handshake
    input wire serial_port_pkg::modem_in_t modem_in,
    output serial_port_pkg::modem_out_t modem_out
);
    serial_port_pkg::state_t s_reg;
    serial_port_pkg::state_t s_next;

    logic divisor_access_select;
    logic loop_on;
    logic rx_line;
    logic [3:0] modem_cur;
    logic [15:0] divisor;
    logic [7:0] lsr_val;
    logic [7:0] iir_val;
    logic [7:0] msr_val;
    logic line_pend;
    logic data_pend;
    logic tx_holding_empty_pend;
    logic modem_pend;
    logic pending;
    logic rd_hit;
    logic wr_hit;
    logic rx_done;

    // Parity bit for the active word length
    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_control_reg);
        logic [7:0] m;
        m = d & (8'hff >> (2'h3 - line_control_reg[1:0]));
        if (line_control_reg[serial_port_pkg::LCR_STICK]) begin
            return ~line_control_reg[serial_port_pkg::LCR_EVEN];
        end
        return line_control_reg[serial_port_pkg::LCR_EVEN] ? ^m : ~^m;
    endfunction

    assign divisor_access_select = s_reg.line_control_reg[serial_port_pkg::LCR_DIVISOR_ACCESS_SELECT];
    assign loop_on = s_reg.modem_control_reg[serial_port_pkg::MCR_LOOP];
    assign divisor = {s_reg.div_hi, s_reg.div_lo}; // RULE_19
    assign rx_line = loop_on ? s_reg.tx_line : s_reg.rxd_s2; // RULE_22
    // In loopback the control outputs stand in for the modem inputs
    assign modem_cur = loop_on ? {s_reg.modem_control_reg[3], s_reg.modem_control_reg[2], s_reg.modem_control_reg[0], s_reg.modem_control_reg[1]} : s_reg.modem_s2; // RULE_22
    assign rd_hit = host_in.cs && host_in.rd;
    assign wr_hit = host_in.cs && host_in.wr;

    assign line_pend = s_reg.irq_enable_reg[2] && (s_reg.overrun || s_reg.parity_err || s_reg.framing_err || s_reg.break_det);
    assign data_pend = s_reg.irq_enable_reg[0] && s_reg.data_ready;
    assign tx_holding_empty_pend = s_reg.irq_enable_reg[1] && s_reg.thr_empty;
    assign modem_pend = s_reg.irq_enable_reg[3] && (s_reg.msr_delta != 4'h0);
    assign pending = line_pend || data_pend || tx_holding_empty_pend || modem_pend; // RULE_09

    always_comb begin
        iir_val = 8'h01;
        if (line_pend) begin
            iir_val = {5'h00, serial_port_pkg::ID_LINE, 1'b0}; // RULE_23
        end else if (data_pend) begin
            iir_val = {5'h00, serial_port_pkg::ID_DATA, 1'b0};
        end else if (tx_holding_empty_pend) begin
            iir_val = {5'h00, serial_port_pkg::ID_TX_HOLDING_EMPTY, 1'b0};
        end else if (modem_pend) begin
            iir_val = {5'h00, serial_port_pkg::ID_MODEM, 1'b0}; // RULE_10
        end
    end

    assign lsr_val = {1'b0, s_reg.thr_empty && (s_reg.tx_state == serial_port_pkg::TX_IDLE), s_reg.thr_empty,
                      s_reg.break_det, s_reg.framing_err, s_reg.parity_err, s_reg.overrun, s_reg.data_ready}; // RULE_15 RULE_16
    assign msr_val = {modem_cur, s_reg.msr_delta}; // RULE_18

    always_comb begin
        logic [5:0] stop_len;
        logic [2:0] last_bit;
        logic [7:0] rx_word;
        logic ref_tick;
        s_next = s_reg;
        stop_len = serial_port_pkg::TICKS_BIT;
        last_bit = 3'(3'h4 + {1'b0, s_reg.line_control_reg[1:0]}); // RULE_11
        rx_word = s_reg.rx_shift >> (2'h3 - s_reg.line_control_reg[1:0]);
        ref_tick = 1'b0;
        rx_done = 1'b0;

        // Synchronisers
        s_next.rxd_s1 = rxd_in;
        s_next.rxd_s2 = s_reg.rxd_s1;
        s_next.modem_s1 = modem_in;
        s_next.modem_s2 = s_reg.modem_s1;

        // Reference clock by fractional accumulation of the system clock
        if (s_reg.ref_acc + serial_port_pkg::ACC_STEP >= serial_port_pkg::ACC_MOD) begin
            s_next.ref_acc = s_reg.ref_acc + serial_port_pkg::ACC_STEP - serial_port_pkg::ACC_MOD; // RULE_25
            ref_tick = 1'b1;
        end else begin
            s_next.ref_acc = s_reg.ref_acc + serial_port_pkg::ACC_STEP;
        end
        s_next.tick = 1'b0;
        if (ref_tick) begin
            // A zero divisor behaves as one
            if (s_reg.div_cnt + 16'h0001 >= divisor) begin
                s_next.div_cnt = 16'h0000; // RULE_03
                s_next.tick = 1'b1;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 16'h0001;
            end
        end

        // Read data and read side effects; hardware sets below win over these clears
        s_next.rdata = 8'h00;
        if (rd_hit) begin
            case (host_in.addr)
                serial_port_pkg::OFS_DATA: begin
                    s_next.rdata = divisor_access_select ? s_reg.div_lo : s_reg.rx_data; // RULE_06 RULE_07 RULE_21
                    if (!divisor_access_select) begin
                        s_next.data_ready = 1'b0; // RULE_24
                    end
                end
                serial_port_pkg::OFS_IER: s_next.rdata = divisor_access_select ? s_reg.div_hi : {4'h0, s_reg.irq_enable_reg};
                serial_port_pkg::OFS_IIR: s_next.rdata = iir_val; // RULE_08
                serial_port_pkg::OFS_LCR: s_next.rdata = s_reg.line_control_reg;
                serial_port_pkg::OFS_MCR: s_next.rdata = {3'h0, s_reg.modem_control_reg};
                serial_port_pkg::OFS_LSR: begin
                    s_next.rdata = lsr_val;
                    s_next.overrun = 1'b0; // RULE_24
                    s_next.parity_err = 1'b0;
                    s_next.framing_err = 1'b0;
                    s_next.break_det = 1'b0;
                end
                serial_port_pkg::OFS_MSR: begin
                    s_next.rdata = msr_val;
                    s_next.msr_delta = 4'h0; // RULE_24
                end
                default: s_next.rdata = s_reg.scratch;
            endcase
        end

        // Modem change flags
        s_next.msr_prev = modem_cur;
        s_next.msr_delta[0] = s_next.msr_delta[0] | (modem_cur[0] ^ s_reg.msr_prev[0]); // RULE_17
        s_next.msr_delta[1] = s_next.msr_delta[1] | (modem_cur[1] ^ s_reg.msr_prev[1]);
        s_next.msr_delta[2] = s_next.msr_delta[2] | (s_reg.msr_prev[2] & ~modem_cur[2]);
        s_next.msr_delta[3] = s_next.msr_delta[3] | (modem_cur[3] ^ s_reg.msr_prev[3]);

        // Transmitter
        if (s_reg.line_control_reg[serial_port_pkg::LCR_STOP]) begin
            stop_len = (s_reg.line_control_reg[1:0] == 2'h0) ? serial_port_pkg::TICKS_STOP_HALF : serial_port_pkg::TICKS_STOP_TWO; // RULE_02
        end
        if (s_reg.tick) begin
            s_next.tx_tick = s_reg.tx_tick + 6'h01;
        end
        case (s_reg.tx_state)
            serial_port_pkg::TX_IDLE: begin
                if (!s_reg.thr_empty) begin
                    s_next.tx_shift = s_reg.tx_hold;
                    s_next.tx_par = par_bit(s_reg.tx_hold, s_reg.line_control_reg); // RULE_12
                    s_next.thr_empty = 1'b1;
                    s_next.tx_tick = 6'h00;
                    s_next.tx_line = 1'b0;
                    s_next.tx_state = serial_port_pkg::TX_START; // RULE_01
                end
            end
            serial_port_pkg::TX_START, serial_port_pkg::TX_DATA, serial_port_pkg::TX_PAR: begin
                if (s_reg.tick && s_reg.tx_tick == serial_port_pkg::TICKS_BIT - 6'h01) begin // RULE_04
                    s_next.tx_tick = 6'h00;
                    if (s_reg.tx_state == serial_port_pkg::TX_START) begin
                        s_next.tx_bit = 3'h0;
                        s_next.tx_line = s_reg.tx_shift[0];
                        s_next.tx_state = serial_port_pkg::TX_DATA;
                    end else if (s_reg.tx_state == serial_port_pkg::TX_DATA && s_reg.tx_bit != last_bit) begin
                        s_next.tx_bit = s_reg.tx_bit + 3'h1;
                        s_next.tx_shift = s_reg.tx_shift >> 1;
                        s_next.tx_line = s_reg.tx_shift[1];
                    end else if (s_reg.tx_state == serial_port_pkg::TX_DATA &&
                                 s_reg.line_control_reg[serial_port_pkg::LCR_PAR_ON]) begin
                        s_next.tx_line = s_reg.tx_par;
                        s_next.tx_state = serial_port_pkg::TX_PAR;
                    end else begin
                        s_next.tx_line = 1'b1;
                        s_next.tx_state = serial_port_pkg::TX_STOP;
                    end
                end
            end
            serial_port_pkg::TX_STOP: begin
                if (s_reg.tick && s_reg.tx_tick == stop_len - 6'h01) begin
                    s_next.tx_state = serial_port_pkg::TX_IDLE;
                end
            end
            default: s_next.tx_state = serial_port_pkg::TX_IDLE;
        endcase
        // Loopback holds the line marking; break overrides the shifter
        s_next.txd = loop_on | (s_reg.tx_line & ~s_reg.line_control_reg[serial_port_pkg::LCR_BREAK]); // RULE_13 RULE_22

        // Receiver, sampling mid-bit on the sixteen-times tick
        if (s_reg.tick) begin
            s_next.rx_tick = s_reg.rx_tick + 4'h1; // RULE_05
        end
        case (s_reg.rx_state)
            serial_port_pkg::RX_IDLE: begin
                if (!rx_line) begin
                    s_next.rx_tick = 4'h0;
                    s_next.rx_state = serial_port_pkg::RX_START;
                end
            end
            serial_port_pkg::RX_START: begin
                if (s_reg.tick && s_reg.rx_tick == serial_port_pkg::TICKS_MID) begin
                    // A glitch shorter than half a bit is not a start bit
                    s_next.rx_tick = 4'h0;
                    s_next.rx_bit = 3'h0;
                    s_next.rx_state = rx_line ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
                end
            end
            serial_port_pkg::RX_DATA, serial_port_pkg::RX_PAR, serial_port_pkg::RX_STOP: begin
                if (s_reg.tick && s_reg.rx_tick == 4'hf) begin
                    if (s_reg.rx_state == serial_port_pkg::RX_DATA) begin
                        s_next.rx_shift = {rx_line, s_reg.rx_shift[7:1]};
                        s_next.rx_bit = s_reg.rx_bit + 3'h1;
                        if (s_reg.rx_bit == last_bit) begin
                            s_next.rx_state = s_reg.line_control_reg[serial_port_pkg::LCR_PAR_ON] ?
                                serial_port_pkg::RX_PAR : serial_port_pkg::RX_STOP;
                        end
                    end else if (s_reg.rx_state == serial_port_pkg::RX_PAR) begin
                        s_next.rx_par = rx_line;
                        s_next.rx_state = serial_port_pkg::RX_STOP;
                    end else begin
                        rx_done = 1'b1;
                        s_next.rx_data = rx_word;
                        s_next.data_ready = 1'b1;
                        s_next.overrun = s_next.overrun | s_reg.data_ready;
                        s_next.framing_err = s_next.framing_err | ~rx_line;
                        s_next.parity_err = s_next.parity_err | (s_reg.line_control_reg[serial_port_pkg::LCR_PAR_ON] &
                                            (s_reg.rx_par != par_bit(rx_word, s_reg.line_control_reg)));
                        s_next.break_det = s_next.break_det | (rx_word == 8'h00 && !rx_line &&
                                           !(s_reg.line_control_reg[serial_port_pkg::LCR_PAR_ON] && s_reg.rx_par)); // RULE_15
                        // A held break must end before the next start is hunted
                        s_next.rx_state = rx_line ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_BRK;
                    end
                end
            end
            serial_port_pkg::RX_BRK: begin
                if (rx_line) begin
                    s_next.rx_state = serial_port_pkg::RX_IDLE;
                end
            end
            default: s_next.rx_state = serial_port_pkg::RX_IDLE;
        endcase

        // Register writes come last so a new holding byte follows the one just loaded
        if (wr_hit) begin
            case (host_in.addr)
                serial_port_pkg::OFS_DATA: begin
                    if (divisor_access_select) begin
                        s_next.div_lo = host_in.wdata; // RULE_07
                    end else begin
                        s_next.tx_hold = host_in.wdata; // RULE_06
                        s_next.thr_empty = 1'b0;
                    end
                end
                serial_port_pkg::OFS_IER: begin
                    if (divisor_access_select) begin
                        s_next.div_hi = host_in.wdata;
                    end else begin
                        s_next.irq_enable_reg = host_in.wdata[3:0]; // RULE_09
                    end
                end
                serial_port_pkg::OFS_LCR: s_next.line_control_reg = host_in.wdata; // RULE_12
                serial_port_pkg::OFS_MCR: s_next.modem_control_reg = host_in.wdata[4:0]; // RULE_14
                serial_port_pkg::OFS_SCR: s_next.scratch = host_in.wdata;
                default: s_next.scratch = s_next.scratch;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.thr_empty <= 1'b1;
            s_reg.tx_line <= 1'b1;
            s_reg.txd <= 1'b1;
            s_reg.rxd_s1 <= 1'b1;
            s_reg.rxd_s2 <= 1'b1;
            s_reg.tx_state <= serial_port_pkg::TX_IDLE;
            s_reg.rx_state <= serial_port_pkg::RX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_out = s_reg.rdata;
    assign irq_out = pending;
    assign txd_out = s_reg.txd;
    // Control outputs go inactive in loopback
    assign modem_out = loop_on ? 4'h0 : s_reg.modem_control_reg[3:0]; // RULE_14

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_read(logic [2:0] a);
        host_in.cs && host_in.rd && host_in.addr == a;
    endsequence

    chk_iir_format: assert property (s_read(serial_port_pkg::OFS_IIR) |=> // RULE_10
        rdata_out[7:3] == 5'h00 && rdata_out[0] == !$past(pending))
        else $error("identification byte malformed");
    chk_iir_priority: assert property (s_read(serial_port_pkg::OFS_IIR) ##0 line_pend |=> // RULE_23
        rdata_out[2:1] == serial_port_pkg::ID_LINE)
        else $error("line status not highest priority");
    chk_ier_upper: assert property (s_read(serial_port_pkg::OFS_IER) ##0 !divisor_access_select |=> // RULE_09
        rdata_out[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    chk_divisor_read: assert property (s_read(serial_port_pkg::OFS_DATA) ##0 divisor_access_select |=> // RULE_07
        rdata_out == $past(s_reg.div_lo))
        else $error("divisor low byte not returned");
    chk_data_clear: assert property (s_read(serial_port_pkg::OFS_DATA) ##0 !divisor_access_select && !rx_done |=> // RULE_24
        !s_reg.data_ready)
        else $error("data ready not cleared by read");
    chk_break_line: assert property (s_reg.line_control_reg[serial_port_pkg::LCR_BREAK] && !loop_on ##1 // RULE_13
        s_reg.line_control_reg[serial_port_pkg::LCR_BREAK] && !loop_on |=> !txd_out)
        else $error("break not forced on line");
    chk_loop_marking: assert property (loop_on |-> modem_out == 4'h0 ##1 txd_out) // RULE_22
        else $error("line not marking in loopback");
    chk_lsr_empty: assert property (s_read(serial_port_pkg::OFS_LSR) |=> // RULE_16
        !rdata_out[7] && (!rdata_out[6] || rdata_out[5]))
        else $error("shifter empty without holding empty");
    chk_tx_load: assert property (s_reg.tx_state == serial_port_pkg::TX_IDLE && !s_reg.thr_empty && !wr_hit |=> // RULE_01
        s_reg.thr_empty && s_reg.tx_state == serial_port_pkg::TX_START ##1 !txd_out || loop_on)
        else $error("start bit not sent after load");
    chk_ring_edge: assert property ($fell(modem_cur[2]) |=> s_reg.msr_delta[2]) // RULE_17
        else $error("ring trailing edge missed");
endmodule
`default_nettype wire

// File: serial_port_pkg.sv
// Constants, register map and state layout of the asynchronous serial port.
// Assumes one 125 MHz clock; the host reaches the byte registers at eight offsets.
// Summary of operation
// RULE_01: Frame is start, five to eight data bits, optional parity, then stop bits.
// RULE_02: Stop period is one, one and a half (five-bit words only) or two bits.
// RULE_03: Baud generator divides the reference clock by any divisor 1 to 65535.
// RULE_04: Divided clock is sixteen times bit rate; transmitter shifts per sixteen ticks.
// RULE_05: Receiver samples the line on the same sixteen-times clock.
// RULE_06: Access bit clear: offset 0 is receive/transmit data, offset 1 interrupt enable.
// RULE_07: Access bit set: offsets 0 and 1 reach divisor low and high bytes.
// RULE_08: Offsets 2 to 7: identification, line control, modem control, statuses, scratch.
// RULE_09: Enable bits 0 to 3 gate data, holding-empty, line and modem interrupts.
// RULE_10: Identification bit 0 low while pending, bits 2:1 give source, rest zero.
// RULE_11: Line control bits 1:0 pick five, six, seven or eight data bits.
// RULE_12: Line control bits 2 to 5: stop count, parity on, even, stick parity.
// RULE_13: Line control bit 6 forces break; bit 7 is the divisor access select.
// RULE_14: Modem control bits 0 to 4: DTR, RTS, out one, out two, loopback.
// RULE_15: Line status bits 0 to 4: ready, overrun, parity, framing, break.
// RULE_16: Line status bit 5 holding empty, bit 6 shifter also empty, bit 7 zero.
// RULE_17: Modem status bits 0 to 3 flag CTS, DSR, ring trailing, carrier changes.
// RULE_18: Modem status bits 4 to 7 show present CTS, DSR, ring, carrier levels.
// RULE_19: Divisor is one 16-bit value: low byte bits 7:0, high byte 15:8.
// RULE_20: Software programs the divisor for the wanted rate, e.g. 12 for 9600.
// RULE_21: Receive data is eight bits read-only; transmit holding eight bits write-only.
// RULE_22: Loopback feeds transmitter to receiver, modem outputs to inputs; line idles marking.
// RULE_23: Identifier priority: line status 11, data 10, holding empty 01, modem 00.
// RULE_24: Reading line status, modem status or data clears its flags.
// RULE_25: Baud reference is 1.8432 MHz, so divisor one gives 115200 baud.
`default_nettype none
package serial_port_pkg;
    localparam int CLK_FREQ_HZ = 125000000;
    localparam int REF_FREQ_HZ = 1843200;
    localparam int ACC_SCALE = 100;
    localparam logic [20:0] ACC_STEP = 21'(REF_FREQ_HZ / ACC_SCALE);
    localparam logic [20:0] ACC_MOD = 21'(CLK_FREQ_HZ / ACC_SCALE);
    localparam logic [3:0] TICKS_MID = 4'h7;
    localparam logic [5:0] TICKS_BIT = 6'h10;
    localparam logic [5:0] TICKS_STOP_HALF = 6'h18;
    localparam logic [5:0] TICKS_STOP_TWO = 6'h20;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_IIR = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_SCR = 3'h7;
    localparam int LCR_STOP = 2;
    localparam int LCR_PAR_ON = 3;
    localparam int LCR_EVEN = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BREAK = 6;
    localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
    localparam int MCR_LOOP = 4;
    localparam logic [1:0] ID_LINE = 2'h3;
    localparam logic [1:0] ID_DATA = 2'h2;
    localparam logic [1:0] ID_TX_HOLDING_EMPTY = 2'h1;
    localparam logic [1:0] ID_MODEM = 2'h0;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4
    } tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4, RX_BRK = 3'h5
    } rx_state_t;

    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Bit order cts, dsr, ri, dcd from bit 0 upward
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_in_t;

    typedef struct packed {
        logic out2;
        logic out1;
        logic rts;
        logic dtr;
    } modem_out_t;

    typedef struct packed {
        logic [20:0] ref_acc;
        logic [15:0] div_cnt;
        logic tick;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [3:0] irq_enable_reg;
        logic [7:0] line_control_reg;
        logic [4:0] modem_control_reg;
        logic [7:0] scratch;
        logic [7:0] rx_data;
        logic [7:0] tx_hold;
        logic thr_empty;
        tx_state_t tx_state;
        logic [5:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_par;
        logic tx_line;
        logic txd;
        rx_state_t rx_state;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_par;
        logic data_ready;
        logic overrun;
        logic parity_err;
        logic framing_err;
        logic break_det;
        logic [3:0] msr_delta;
        logic [3:0] msr_prev;
        logic rxd_s1;
        logic rxd_s2;
        logic [3:0] modem_s1;
        logic [3:0] modem_s2;
        logic [7:0] rdata;
    } state_t;
endpackage
`default_nettype wire

// File: serial_line_model.sv
// Far end of the serial line: decodes 8N1 frames from the port and sends frames to it.
// Assumes the port runs at divisor 1, so a bit is sixteen ticks of 1.8432 MHz.
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
    // Serial line
    input wire logic txd_in,
    output logic rxd_out
);
    localparam real BIT_NS = 16.0e9 / 1843200.0;
    logic [7:0] sh;
    logic [7:0] rx_q[$];
    // Idle marking between frames
    initial rxd_out = 1'b1;
    always @(negedge txd_in) begin
        #(BIT_NS * 1.5);
        for (int i = 0; i < 8; i++) begin
            sh[i] = txd_in;
            #(BIT_NS);
        end
        // Only a frame with a good stop bit counts
        if (txd_in === 1'b1) rx_q.push_back(sh);
    end
    task automatic send(input logic [7:0] d, input int n, input logic bad);
        rxd_out = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < n; i++) begin
            rxd_out = d[i];
            #(BIT_NS);
        end
        // Even parity; bad flips it
        rxd_out = ^d ^ bad;
        #(BIT_NS);
        rxd_out = 1'b1;
        #(BIT_NS);
    endtask
endmodule
`default_nettype wire

// File: async_serial_port_tb.sv
// Self-checking bench for the serial port with a line model at the far end.
// Assumes divisor 1 for traffic so each frame costs about eleven thousand cycles.
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_tb;
    logic mclk_in;
    logic nrst_in;
    serial_port_pkg::host_req_t host_in;
    logic [7:0] rdata_out;
    logic irq_out;
    logic rxd;
    logic txd_out;
    serial_port_pkg::modem_in_t modem_in;
    serial_port_pkg::modem_out_t modem_out;
    int errors = 0;
    int check_count = 0;
    logic [7:0] mdl [8];
    logic [7:0] dl [2];
    logic [7:0] d;
    async_serial_port u_async_serial_port (.mclk_in(mclk_in), .nrst_in(nrst_in), .host_in(host_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .rxd_in(rxd), .txd_out(txd_out),
        .modem_in(modem_in), .modem_out(modem_out));
    serial_line_model u_serial_line_model (.txd_in(txd_out), .rxd_out(rxd));
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] v);
        @(posedge mclk_in);
        #1 host_in = '{cs: 1'b1, rd: ~w, wr: w, addr: a, wdata: v};
        @(posedge mclk_in);
        #1 host_in = '0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        acc(a, 1'b1, v);
        if (a < 3'h2 && mdl[3][7]) dl[a[0]] = v;
        else if (a == 3'h1) mdl[1] = v & 8'h0f;
        else if (a == 3'h4) mdl[4] = v & 8'h1f;
        else mdl[a] = v;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        acc(a, 1'b0, 8'h00);
        chk(rdata_out, exp);
    endtask
    function automatic logic [7:0] exp_rd(input logic [2:0] a);
        return (a < 3'h2 && mdl[3][7]) ? dl[a[0]] : mdl[a];
    endfunction
    initial begin
        host_in = '0;
        modem_in = '0;
        nrst_in = 1'b0;
        mdl = '{default: 8'h00};
        void'($urandom(32'h40299b46));
        repeat (6) @(posedge mclk_in);
        #1 nrst_in = 1'b1;
        chk({7'h00, txd_out}, 8'h01);
        rd_chk(3'h5, 8'h60);
        rd_chk(3'h2, 8'h01);
        for (int i = 0; i < 4; i++) begin
            // Break bit kept clear so the line model sees no false start
            wr(3'h3, 8'h80 | (8'($urandom) & 8'hbf));
            wr(3'h0, 8'($urandom));
            wr(3'h1, 8'($urandom));
            wr(3'h7, 8'($urandom));
            wr(3'h3, mdl[3] & 8'h7f);
            wr(3'h1, 8'($urandom) & 8'h0f);
            wr(3'h4, 8'($urandom) & 8'h0f);
            chk(8'(modem_out), mdl[4]);
            foreach (mdl[a]) if (a != 0 && a != 2 && a < 5 || a == 7) rd_chk(3'(a), exp_rd(3'(a)));
            wr(3'h3, mdl[3] | 8'h80);
            rd_chk(3'h0, exp_rd(3'h0));
            rd_chk(3'h1, exp_rd(3'h1));
        end
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'h02);
        rd_chk(3'h1, 8'h02);
        rd_chk(3'h2, 8'h02);
        chk({7'h00, irq_out}, 8'h01);
        d = 8'($urandom);
        wr(3'h0, d);
        for (int t = 0; t < 15000 && u_serial_line_model.rx_q.size() == 0; t++) @(posedge mclk_in);
        if (u_serial_line_model.rx_q.size() == 0) begin
            errors++;
            tally_and_finish();
        end
        chk(u_serial_line_model.rx_q.pop_front(), d);
        repeat (800) @(posedge mclk_in);
        rd_chk(3'h5, 8'h60);
        wr(3'h3, 8'h1a);
        wr(3'h1, 8'h05);
        d = 8'($urandom) & 8'h7f;
        u_serial_line_model.send(d, 7, 1'b0);
        repeat (100) @(posedge mclk_in);
        rd_chk(3'h2, 8'h04);
        rd_chk(3'h5, 8'h61);
        rd_chk(3'h0, d);
        rd_chk(3'h5, 8'h60);
        u_serial_line_model.send(d, 7, 1'b1);
        repeat (100) @(posedge mclk_in);
        rd_chk(3'h2, 8'h06);
        rd_chk(3'h5, 8'h65);
        rd_chk(3'h5, 8'h61);
        rd_chk(3'h0, d);
        wr(3'h1, 8'h08);
        modem_in = 4'h1;
        repeat (5) @(posedge mclk_in);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h6, 8'h11);
        rd_chk(3'h6, 8'h10);
        wr(3'h4, 8'h1f);
        chk({3'h0, txd_out, modem_out}, 8'h10);
        // Dropping out one in loopback is a trailing ring edge
        wr(3'h4, 8'h1b);
        rd_chk(3'h6, 8'hbe);
        wr(3'h0, d);
        repeat (11500) @(posedge mclk_in);
        rd_chk(3'h5, 8'h61);
        rd_chk(3'h0, d);
        wr(3'h4, 8'h00);
        wr(3'h3, 8'h5a);
        @(posedge mclk_in);
        #1 chk({7'h00, txd_out}, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
